// ==== hw/usb_fs_dev.sv ====
`default_nettype none
module usb_fs_dev
  import usb_fs_dev_pkg::*;
#(
  parameter int SUSPEND_CYCLES = SUSPEND_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sof_rx,
  input wire logic se0,
  input wire logic periph_tick,
  input wire logic dplus_pad,
  input wire logic supply_present,
  input wire logic setup_rx,
  input wire logic ep0_done,
  input wire logic ep0_wr,
  input wire logic [2:0] ep0_wr_idx,
  input wire logic [7:0] ep0_wr_byte,
  input wire logic [7:0] ep_done,
  input wire logic [7:0] ep_nak,
  input wire logic [7:0] ep_err,
  input wire logic [7:0] ep_in_tok,
  input wire logic [7:0] ep_out_tok,
  input wire logic lpm_token,
  input wire logic [3:0] lpm_besl,
  input wire logic lpm_rwake,
  input wire logic arb_event,
  input wire logic sie_req,
  input wire logic sie_we,
  input wire logic [2:0] sie_ep,
  input wire logic [15:0] sie_wdata,
  output logic sie_gnt,
  output logic [15:0] sie_rdata,
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [2:0] dma_ep,
  input wire logic [15:0] dma_wdata,
  output logic dma_gnt,
  output logic [15:0] dma_rdata,
  output logic dplus_pullup_enable,
  output logic pin_gpio_select,
  output logic lpm_enable,
  output logic [1:0] lpm_handshake,
  output logic [1:0] lpm_other_resp,
  output logic suspended,
  output logic [7:0] endpoint_active_reg,
  output logic [7:0] ep_dir_in,
  output logic [63:0] ep0_data,
  output logic irq_line_low,
  output logic irq_line_medium,
  output logic irq_line_high
);
  // Refuse idle limits the counter cannot hold
  if (SUSPEND_CYCLES < 1 || SUSPEND_CYCLES >= (1 << IDLE_W)) begin : g_bad_idle
    $error("SUSPEND_CYCLES out of range");
  end

  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(SUSPEND_CYCLES - 1);

  // Register state
  logic [4:0] link_power_control_reg;
  logic [4:0] link_power_status_reg;
  logic [7:0] bus_reset_count_reg;
  logic auto_mode;
  logic [2:0] cpu_ep;
  logic [4:0] engine_irq_status_reg;
  logic [4:0] engine_irq_mask_reg;
  logic [7:0] endpoint_irq_enable_reg;
  logic [7:0] endpoint_irq_status_reg;
  logic [27:0] irq_level_select_reg;
  logic supply_change_status_reg;
  logic supply_change_mask_reg;
  logic supply_prev;
  logic [7:0] endpoint_control_reg [NUM_EP];
  logic [7:0] wr_ptr [NUM_EP];
  logic [7:0] rd_ptr [NUM_EP];
  logic [15:0] mem [MEM_WORDS];
  logic [7:0] rst_cnt;
  logic rst_fired;
  logic [IDLE_W-1:0] idle_cnt;
  logic cpu_pend;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;

  // APB phase decode
  wire setup_ph = psel & ~penable;
  wire acc_ph = psel & penable;
  wire hit_ctl = paddr[7:5] == A_EP_CTL_BLK;
  wire hit_ptr = paddr[7:5] == A_EP_PTR_BLK;
  wire [2:0] reg_ep = paddr[4:2];
  wire mem_hit = paddr == A_MEM_DATA;
  wire wr_en = pready & pwrite;
  wire w_power = wr_en & (paddr == A_POWER);
  wire w_pin = wr_en & (paddr == A_PIN);
  wire w_lpm = wr_en & (paddr == A_LINK_POWER_CONTROL_REG);
  wire w_act = wr_en & (paddr == A_ENDPOINT_ACTIVE_REG);
  wire w_dir = wr_en & (paddr == A_EP_DIR);
  wire w_cnt = wr_en & (paddr == A_RST_CNT);
  wire w_cfg = wr_en & (paddr == A_MEM_CFG);
  wire w_stat = wr_en & (paddr == A_ENG_STAT);
  wire w_mask = wr_en & (paddr == A_ENG_MASK);
  wire w_force = wr_en & (paddr == A_ENG_FORCE);
  wire w_epen = wr_en & (paddr == A_EP_IRQ_EN);
  wire w_epst = wr_en & (paddr == A_EP_IRQ_STAT);
  wire w_lvl = wr_en & (paddr == A_LVL_SEL);
  wire w_schg = wr_en & (paddr == A_SUPPLY_CHG);
  wire w_smask = wr_en & (paddr == A_SUPPLY_MASK);
  wire w_ep0lo = wr_en & (paddr == A_EP0_LO);
  wire w_ep0hi = wr_en & (paddr == A_EP0_HI);
  wire w_ctl = wr_en & hit_ctl;
  // Pointers belong to the block in automatic mode
  wire w_ptr = wr_en & hit_ptr & ~auto_mode;

  // Arbiter: engine first, then DMA, CPU last; CPU may wait behind streams
  wire g_sie = ce & sie_req;
  wire g_dma = ce & dma_req & ~sie_req;
  wire g_cpu = ce & cpu_pend & ~sie_req & ~dma_req;
  wire g_any = g_sie | g_dma | g_cpu;
  wire [2:0] a_ep = g_sie ? sie_ep : (g_dma ? dma_ep : cpu_ep);
  wire a_we = g_sie ? sie_we : (g_dma ? dma_we : pwrite);
  wire [15:0] a_wd = g_sie ? sie_wdata : (g_dma ? dma_wdata : pwdata[15:0]);
  wire [7:0] a_ptr = a_we ? wr_ptr[a_ep] : rd_ptr[a_ep];
  wire [7:0] a_ptr_inc = 8'(a_ptr + 8'h01);
  // Automatic mode gives each endpoint a fixed 32-word region
  wire [7:0] a_addr = auto_mode ? {a_ep, a_ptr[4:0]} : a_ptr;
  wire a_ok = ~auto_mode | endpoint_active_reg[a_ep];
  wire [15:0] a_rd = a_ok ? mem[a_addr] : 16'h0000;
  assign sie_gnt = g_sie;
  assign dma_gnt = g_dma;

  // APB answer; memory window waits for its grant
  assign pready = acc_ph & ce & ~cpu_pend;
  assign prdata = prdata_q;

  // Engine event sources
  wire [4:0] eng_set;
  assign eng_set[EV_SOF] = sof_rx;
  assign eng_set[EV_BUSRST] = se0 & periph_tick & ~rst_fired & (8'(rst_cnt + 8'h01) >= bus_reset_count_reg);
  assign eng_set[EV_EP0] = ep0_done | setup_rx;
  assign eng_set[EV_LPM] = lpm_token;
  assign eng_set[EV_WAKE] = ~dplus_pad;
  wire [4:0] eng_force = w_force ? pwdata[4:0] : 5'h00;
  wire [4:0] eng_masked = engine_irq_status_reg & engine_irq_mask_reg;

  // Endpoint events: completion, NAK, error, stall
  wire [7:0] ep_ev;
  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    wire [1:0] mode = endpoint_control_reg[e][3:2];
    wire stall_ev = endpoint_control_reg[e][CTL_STALL] &
      ((ep_out_tok[e] & (mode == MODE_ACK_OUT)) | (ep_in_tok[e] & (mode == MODE_ACK_IN)));
    assign ep_ev[e] = ep_done[e] | (ep_nak[e] & endpoint_control_reg[e][CTL_NAK_EN]) |
      ep_err[e] | stall_ev;
  end
  wire [7:0] ep_set = ep_ev & endpoint_irq_enable_reg;

  // Interrupt routing over fourteen sources
  wire [NUM_EV-1:0] pend = {arb_event, eng_masked[EV_WAKE], eng_masked[EV_LPM],
    eng_masked[EV_EP0], endpoint_irq_status_reg, eng_masked[EV_BUSRST], eng_masked[EV_SOF]};
  wire [NUM_EV-1:0] cause_low_reg;
  wire [NUM_EV-1:0] cause_medium_reg;
  wire [NUM_EV-1:0] cause_high_reg;
  for (genvar i = 0; i < NUM_EV; i++) begin : g_lvl
    wire [1:0] lvl = irq_level_select_reg[2*i+:2];
    assign cause_low_reg[i] = pend[i] & (lvl == LVL_LOW);
    assign cause_medium_reg[i] = pend[i] & (lvl == LVL_MED);
    assign cause_high_reg[i] = pend[i] & (lvl == LVL_HIGH);
  end
  assign irq_line_low = |cause_low_reg;
  assign irq_line_medium = |cause_medium_reg;
  assign irq_line_high = |cause_high_reg;

  // Read selection; addresses above the memory window and outside the endpoint blocks answer with an error
  wire mapped = (paddr <= A_MEM_DATA) | hit_ctl | hit_ptr;
  assign pslverr = acc_ph & ~mapped;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      A_POWER: rd_mux[0] = dplus_pullup_enable;
      A_PIN: rd_mux[0] = pin_gpio_select;
      A_LINK_POWER_CONTROL_REG: rd_mux[4:0] = link_power_control_reg;
      A_LINK_POWER_STATUS_REG: rd_mux[8:0] = {suspended, 3'h0, link_power_status_reg};
      A_ENDPOINT_ACTIVE_REG: rd_mux[7:0] = endpoint_active_reg;
      A_EP_DIR: rd_mux[7:0] = ep_dir_in;
      A_RST_CNT: rd_mux[7:0] = bus_reset_count_reg;
      A_MEM_CFG: rd_mux[6:0] = {cpu_ep, 3'h0, auto_mode};
      A_ENG_STAT: rd_mux[4:0] = engine_irq_status_reg;
      A_ENG_MASK: rd_mux[4:0] = engine_irq_mask_reg;
      A_ENG_MASKED: rd_mux[4:0] = eng_masked;
      A_EP_IRQ_EN: rd_mux[7:0] = endpoint_irq_enable_reg;
      A_EP_IRQ_STAT: rd_mux[7:0] = endpoint_irq_status_reg;
      A_LVL_SEL: rd_mux[27:0] = irq_level_select_reg;
      A_CAUSE_LO: rd_mux[13:0] = cause_low_reg;
      A_CAUSE_MED: rd_mux[13:0] = cause_medium_reg;
      A_CAUSE_HI: rd_mux[13:0] = cause_high_reg;
      A_SUPPLY: rd_mux[SUPPLY_BIT] = supply_present;
      A_SUPPLY_CHG: rd_mux[SUPPLY_BIT] = supply_change_status_reg;
      A_SUPPLY_MASK: rd_mux[SUPPLY_BIT] = supply_change_mask_reg;
      A_EP0_LO: rd_mux = ep0_data[31:0];
      A_EP0_HI: rd_mux = ep0_data[63:32];
      default: begin
        if (hit_ctl) begin
          rd_mux[7:0] = endpoint_control_reg[reg_ep];
        end else if (hit_ptr) begin
          rd_mux[15:0] = {rd_ptr[reg_ep], wr_ptr[reg_ep]};
        end
      end
    endcase
  end

  // Bus side: read capture and pending memory window
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
      cpu_pend <= 1'b0;
    end else if (ce) begin
      if (setup_ph) begin
        prdata_q <= rd_mux;
        cpu_pend <= mem_hit;
      end else if (g_cpu) begin
        prdata_q <= {16'h0000, a_rd};
        cpu_pend <= 1'b0;
      end
    end
  end

  // Shared endpoint memory, no reset on the array
  always_ff @(posedge clk_sys) begin
    if (ce && g_any && a_ok && a_we) begin
      mem[a_addr] <= a_wd;
    end
  end

  // Engine and DMA read data, valid the cycle after grant
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sie_rdata <= 16'h0000;
      dma_rdata <= 16'h0000;
    end else if (ce) begin
      if (g_sie && !a_we) sie_rdata <= a_rd;
      if (g_dma && !a_we) dma_rdata <= a_rd;
    end
  end

  // Endpoint pointers and control registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int e = 0; e < NUM_EP; e++) begin
        wr_ptr[e] <= 8'h00;
        rd_ptr[e] <= 8'h00;
        endpoint_control_reg[e] <= 8'h00;
      end
    end else if (ce) begin
      if (w_ptr) begin
        wr_ptr[reg_ep] <= pwdata[7:0];
        rd_ptr[reg_ep] <= pwdata[15:8];
      end
      if (g_any && a_ok && a_we) wr_ptr[a_ep] <= a_ptr_inc;
      if (g_any && a_ok && !a_we) rd_ptr[a_ep] <= a_ptr_inc;
      for (int e = 0; e < NUM_EP; e++) begin
        if (w_ctl && reg_ep == 3'(e)) begin
          endpoint_control_reg[e][3:0] <= pwdata[3:0];
          if (pwdata[CTL_ERR]) endpoint_control_reg[e][CTL_ERR] <= 1'b0;
        end
        // Error flag set wins over its clear
        if (ep_err[e]) endpoint_control_reg[e][CTL_ERR] <= 1'b1;
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dplus_pullup_enable <= 1'b0;
      pin_gpio_select <= 1'b0;
      link_power_control_reg <= 5'h00;
      endpoint_active_reg <= 8'h00;
      ep_dir_in <= 8'h00;
      bus_reset_count_reg <= RST_CNT_RESET;
      auto_mode <= 1'b0;
      cpu_ep <= 3'h0;
      engine_irq_mask_reg <= 5'h00;
      endpoint_irq_enable_reg <= 8'h00;
      irq_level_select_reg <= 28'h000_0000;
      supply_change_mask_reg <= 1'b0;
    end else if (ce) begin
      if (w_power) dplus_pullup_enable <= pwdata[0];
      if (w_pin) pin_gpio_select <= pwdata[0];
      if (w_lpm) link_power_control_reg <= pwdata[4:0];
      if (w_act) endpoint_active_reg <= pwdata[7:0];
      if (w_dir) ep_dir_in <= pwdata[7:0];
      if (w_cnt) bus_reset_count_reg <= pwdata[7:0];
      if (w_cfg) begin
        auto_mode <= pwdata[0];
        cpu_ep <= pwdata[6:4];
      end
      if (w_mask) engine_irq_mask_reg <= pwdata[4:0];
      if (w_epen) endpoint_irq_enable_reg <= pwdata[7:0];
      if (w_lvl) irq_level_select_reg <= pwdata[27:0];
      if (w_smask) supply_change_mask_reg <= pwdata[SUPPLY_BIT];
    end
  end
  assign lpm_enable = link_power_control_reg[0];
  assign lpm_handshake = link_power_control_reg[2:1];
  assign lpm_other_resp = link_power_control_reg[4:3];

  // Sticky status: hardware set wins over a write-one clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      engine_irq_status_reg <= 5'h00;
      endpoint_irq_status_reg <= 8'h00;
      supply_change_status_reg <= 1'b0;
      supply_prev <= 1'b0;
    end else if (ce) begin
      engine_irq_status_reg <= (engine_irq_status_reg & ~(w_stat ? pwdata[4:0] : 5'h00))
        | eng_set | eng_force;
      endpoint_irq_status_reg <= (endpoint_irq_status_reg & ~(w_epst ? pwdata[7:0] : 8'h00))
        | ep_set;
      supply_prev <= supply_present;
      supply_change_status_reg <= (supply_change_status_reg & ~(w_schg & pwdata[SUPPLY_BIT]))
        | (supply_present ^ supply_prev);
    end
  end

  // LPM capture, endpoint 0 bytes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link_power_status_reg <= 5'h00;
      ep0_data <= 64'h0000_0000_0000_0000;
    end else if (ce) begin
      if (lpm_token) link_power_status_reg <= {lpm_rwake, lpm_besl};
      if (w_ep0lo) ep0_data[31:0] <= pwdata;
      if (w_ep0hi) ep0_data[63:32] <= pwdata;
      // Engine byte write wins over a same-cycle CPU write
      if (ep0_wr) ep0_data[8*ep0_wr_idx+:8] <= ep0_wr_byte;
    end
  end

  // Bus reset timer on peripheral ticks, fires once per SE0
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rst_cnt <= 8'h00;
      rst_fired <= 1'b0;
    end else if (ce) begin
      if (!se0) begin
        rst_cnt <= 8'h00;
        rst_fired <= 1'b0;
      end else if (periph_tick && !rst_fired) begin
        rst_cnt <= 8'(rst_cnt + 8'h01);
        if (eng_set[EV_BUSRST]) rst_fired <= 1'b1;
      end
    end
  end

  // Suspend after a frame-start drought
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      idle_cnt <= '0;
      suspended <= 1'b0;
    end else if (ce) begin
      if (sof_rx) begin
        idle_cnt <= '0;
        suspended <= 1'b0;
      end else if (idle_cnt == IDLE_LAST) begin
        suspended <= 1'b1;
      end else begin
        idle_cnt <= IDLE_W'(idle_cnt + 1'b1);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_apb_write(logic [7:0] a);
    ce && psel && penable && pready && pwrite && paddr == a;
  endsequence

  property p_masked_read;
    ce && setup_ph && paddr == A_ENG_MASKED
      |=> prdata[4:0] == ($past(engine_irq_status_reg) & $past(engine_irq_mask_reg));
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked status wrong");

  property p_sof_sets;
    ce && sof_rx |=> engine_irq_status_reg[EV_SOF] && !suspended;
  endproperty
  a_sof_sets: assert property (p_sof_sets) else $error("frame start lost");

  property p_busrst;
    ce && se0 && periph_tick && !rst_fired && 8'(rst_cnt + 8'h01) >= bus_reset_count_reg
      |=> engine_irq_status_reg[EV_BUSRST] && rst_fired;
  endproperty
  a_busrst: assert property (p_busrst) else $error("bus reset not raised");

  property p_suspend;
    ce && !sof_rx && idle_cnt == IDLE_LAST |=> suspended;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend missed");

  property p_one_grant;
    $onehot0({sie_gnt, dma_gnt, g_cpu});
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("two grants");

  property p_ep_gated;
    ce |=> ((endpoint_irq_status_reg & ~$past(endpoint_irq_status_reg))
      & ~$past(endpoint_irq_enable_reg)) == 8'h00;
  endproperty
  a_ep_gated: assert property (p_ep_gated) else $error("disabled endpoint set");

  property p_pullup;
    s_apb_write(A_POWER) |=> dplus_pullup_enable == $past(pwdata[0]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not updated");

  property p_supply;
    ce && supply_present != supply_prev |=> supply_change_status_reg;
  endproperty
  a_supply: assert property (p_supply) else $error("supply change lost");

  property p_wake;
    ce && !dplus_pad |=> engine_irq_status_reg[EV_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("resume lost");

  property p_err_flag;
    ce && ep_err[0] && endpoint_irq_enable_reg[0]
      |=> endpoint_control_reg[0][CTL_ERR] && endpoint_irq_status_reg[0];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag missed");
endmodule
`default_nettype wire

// ==== hw/usb_fs_dev_pkg.sv ====
`default_nettype none
package usb_fs_dev_pkg;
  // Clock and suspend timing
  localparam int CLK_MHZ = 100;
  localparam int SUSPEND_US = 3000;
  localparam int SUSPEND_CYCLES_DEF = SUSPEND_US * CLK_MHZ;
  localparam int IDLE_W = 19;
  // Endpoint memory shape
  localparam int MEM_WORDS = 256;
  localparam int NUM_EP = 8;
  localparam int NUM_EV = 14;
  // Register byte offsets
  localparam logic [7:0] A_POWER = 8'h00;
  localparam logic [7:0] A_PIN = 8'h04;
  localparam logic [7:0] A_LINK_POWER_CONTROL_REG = 8'h08;
  localparam logic [7:0] A_LINK_POWER_STATUS_REG = 8'h0c;
  localparam logic [7:0] A_ENDPOINT_ACTIVE_REG = 8'h10;
  localparam logic [7:0] A_EP_DIR = 8'h14;
  localparam logic [7:0] A_RST_CNT = 8'h18;
  localparam logic [7:0] A_MEM_CFG = 8'h1c;
  localparam logic [7:0] A_ENG_STAT = 8'h20;
  localparam logic [7:0] A_ENG_MASK = 8'h24;
  localparam logic [7:0] A_ENG_MASKED = 8'h28;
  localparam logic [7:0] A_ENG_FORCE = 8'h2c;
  localparam logic [7:0] A_EP_IRQ_EN = 8'h30;
  localparam logic [7:0] A_EP_IRQ_STAT = 8'h34;
  localparam logic [7:0] A_LVL_SEL = 8'h38;
  localparam logic [7:0] A_CAUSE_LO = 8'h3c;
  localparam logic [7:0] A_CAUSE_MED = 8'h40;
  localparam logic [7:0] A_CAUSE_HI = 8'h44;
  localparam logic [7:0] A_SUPPLY = 8'h48;
  localparam logic [7:0] A_SUPPLY_CHG = 8'h4c;
  localparam logic [7:0] A_SUPPLY_MASK = 8'h50;
  localparam logic [7:0] A_EP0_LO = 8'h54;
  localparam logic [7:0] A_EP0_HI = 8'h58;
  localparam logic [7:0] A_MEM_DATA = 8'h5c;
  localparam logic [2:0] A_EP_CTL_BLK = 3'h3;
  localparam logic [2:0] A_EP_PTR_BLK = 3'h4;
  // Field positions
  localparam int SUPPLY_BIT = 5;
  localparam int EV_SOF = 0;
  localparam int EV_BUSRST = 1;
  localparam int EV_EP0 = 2;
  localparam int EV_LPM = 3;
  localparam int EV_WAKE = 4;
  localparam int CTL_NAK_EN = 0;
  localparam int CTL_STALL = 1;
  localparam int CTL_ERR = 7;
  // Reset values
  localparam logic [7:0] RST_CNT_RESET = 8'h0a;
  // Endpoint modes and interrupt levels
  typedef enum logic [1:0] {
    MODE_IGNORE = 2'b00, MODE_ACK_IN = 2'b01, MODE_ACK_OUT = 2'b10, MODE_NAK = 2'b11
  } ep_mode_t;
  localparam logic [1:0] LVL_LOW = 2'b00;
  localparam logic [1:0] LVL_MED = 2'b01;
  localparam logic [1:0] LVL_HIGH = 2'b10;
endpackage
`default_nettype wire

// ==== tb/usb_host_model.sv ====
`default_nettype none
module usb_host_model (
  input wire logic clk_sys,
  output logic sof_rx,
  output logic se0,
  output logic periph_tick,
  output logic dplus_pad,
  output logic lpm_token,
  output logic [3:0] lpm_besl,
  output logic lpm_rwake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div = 4'h0;
  // Idle bus: J state keeps D+ high
  initial begin
    sof_rx = 0;
    se0 = 0;
    periph_tick = 0;
    dplus_pad = 1;
    lpm_token = 0;
    lpm_besl = 4'h0;
    lpm_rwake = 0;
  end
  // Divided peripheral clock, scaled to one tick per 10 cycles for run time
  always @(posedge clk_sys) begin
    div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
    periph_tick <= (div == 4'h9);
  end
  task automatic sof();
    @(posedge clk_sys);
    sof_rx <= 1;
    @(posedge clk_sys);
    sof_rx <= 0;
  endtask
  // Token fields go stale after the pulse, so they are inverted
  task automatic lpm(input logic [3:0] b, input logic w);
    @(posedge clk_sys);
    lpm_token <= 1;
    lpm_besl <= b;
    lpm_rwake <= w;
    @(posedge clk_sys);
    lpm_token <= 0;
    lpm_besl <= ~b;
    lpm_rwake <= ~w;
  endtask
  task automatic hold_se0(input int n);
    @(posedge clk_sys);
    se0 <= 1;
    repeat (n) @(posedge clk_sys);
    se0 <= 0;
  endtask
  task automatic wake();
    @(posedge clk_sys);
    dplus_pad <= 0;
    @(posedge clk_sys);
    dplus_pad <= 1;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_usb_fs_dev.sv ====
`default_nettype none
module tb_usb_fs_dev import usb_fs_dev_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0;
  logic reset = 1;
  logic ce = 1;
  logic psel = 0, penable = 0, pwrite = 0, supply_present = 0, perr;
  logic [7:0] paddr = 8'h00, ep_done = 8'h00, ep_err = 8'h00, q = 8'h00;
  logic [7:0] ep_nak = 8'h00, ep_in_tok = 8'h00, endpoint_active_reg;
  logic setup_rx = 0, sie_req = 0, arb_event = 0;
  logic sie_gnt, irq_line_low, irq_line_medium, irq_line_high;
  logic [15:0] sie_rdata;
  logic [63:0] ep0_data;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, dplus_pullup_enable, pin_gpio_select, lpm_enable, suspended;
  logic [1:0] lpm_handshake, lpm_other_resp;
  logic [7:0] ep_dir_in;
  wire logic sof_rx, se0, periph_tick, dplus_pad, lpm_token, lpm_rwake;
  wire logic [3:0] lpm_besl;
  int n_errors = 0, samples_checked = 0;
  // System clock stands in for the USB clock; the block sees only cycles
  always #5 clk_sys = ~clk_sys;
  usb_host_model host_u (.clk_sys, .sof_rx, .se0, .periph_tick, .dplus_pad, .lpm_token,
    .lpm_besl, .lpm_rwake);
  // Data-path inputs other than sie_req held quiet; register side exercised except A_SUPPLY_MASK and A_EP0_HI
  usb_fs_dev #(.SUSPEND_CYCLES(50)) dut_u (.clk_sys, .reset, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sof_rx, .se0, .periph_tick, .dplus_pad,
    .supply_present, .setup_rx, .ep0_done(q[0]), .ep0_wr(q[0]), .ep0_wr_idx(q[2:0]),
    .ep0_wr_byte(q), .ep_done, .ep_nak, .ep_err, .ep_in_tok, .ep_out_tok(q),
    .lpm_token, .lpm_besl, .lpm_rwake, .arb_event, .sie_req, .sie_we(q[0]),
    .sie_ep(q[2:0]), .sie_wdata({q, q}), .sie_gnt, .sie_rdata, .dma_req(q[0]),
    .dma_we(q[0]), .dma_ep(q[2:0]), .dma_wdata({q, q}), .dma_gnt(), .dma_rdata(),
    .dplus_pullup_enable, .pin_gpio_select, .lpm_enable, .lpm_handshake, .lpm_other_resp,
    .suspended, .endpoint_active_reg, .ep_dir_in, .ep0_data, .irq_line_low, .irq_line_medium,
    .irq_line_high);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Master waits on pready with no assumed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdat = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask
  // One-cycle NAK and IN token pulses on the data endpoints
  task automatic ep_pulse(input logic [7:0] n, input logic [7:0] t);
    @(posedge clk_sys);
    ep_nak <= n;
    ep_in_tok <= t;
    @(posedge clk_sys);
    ep_nak <= 8'h00;
    ep_in_tok <= 8'h00;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles of the sequence
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 0;
    rd(A_RST_CNT, 32'h0000_000a);
    rd(8'hfc, 32'h0000_0000);
    chk({31'h0, perr}, 32'h0000_0001);
    wr(A_POWER, 1);
    wr(A_PIN, 1);
    wr(A_LINK_POWER_CONTROL_REG, 32'h0000_001d);
    wr(A_ENDPOINT_ACTIVE_REG, 32'h0000_00c3);
    wr(A_EP_DIR, 32'h0000_00a5);
    // The last write lands at the very edge that ends it
    @(posedge clk_sys);
    chk({25'h0, dplus_pullup_enable, pin_gpio_select, lpm_enable, lpm_handshake,
      lpm_other_resp}, 32'h0000_007b);
    chk({16'h0, endpoint_active_reg, ep_dir_in}, 32'h0000_c3a5);
    host_u.sof();
    repeat (3) @(posedge clk_sys);
    chk({31'h0, suspended}, 32'h0000_0000);
    repeat (40) @(posedge clk_sys);
    chk({31'h0, suspended}, 32'h0000_0000);
    repeat (20) @(posedge clk_sys);
    chk({31'h0, suspended}, 32'h0000_0001);
    rd(A_ENG_STAT, 32'h0000_0001);
    wr(A_ENG_MASK, 1);
    rd(A_ENG_MASKED, 32'h0000_0001);
    wr(A_ENG_STAT, 1);
    rd(A_ENG_STAT, 32'h0000_0000);
    // Clock enable low must freeze the status bits
    ce <= 0;
    host_u.wake();
    ce <= 1;
    rd(A_ENG_STAT, 32'h0000_0000);
    host_u.lpm(4'h9, 1'b1);
    rd(A_LINK_POWER_STATUS_REG, 32'h0000_0119);
    host_u.wake();
    rd(A_ENG_STAT, 32'h0000_0018);
    // Too short for three ticks, then long enough
    wr(A_RST_CNT, 3);
    host_u.hold_se0(15);
    rd(A_ENG_STAT, 32'h0000_0018);
    host_u.hold_se0(40);
    rd(A_ENG_STAT, 32'h0000_001a);
    wr(A_ENG_FORCE, 4);
    rd(A_ENG_STAT, 32'h0000_001e);
    wr(A_ENG_STAT, 32'h0000_0004);
    rd(A_ENG_STAT, 32'h0000_001a);
    @(posedge clk_sys);
    setup_rx <= 1;
    @(posedge clk_sys);
    setup_rx <= 0;
    rd(A_ENG_STAT, 32'h0000_001e);
    supply_present <= 1;
    rd(A_SUPPLY, 32'h0000_0020);
    rd(A_SUPPLY_CHG, 32'h0000_0020);
    wr(A_SUPPLY_CHG, 32'h0000_0020);
    rd(A_SUPPLY_CHG, 32'h0000_0000);
    // Supply goes away: firmware drops the pull-up
    supply_present <= 0;
    rd(A_SUPPLY, 32'h0000_0000);
    rd(A_SUPPLY_CHG, 32'h0000_0020);
    wr(A_POWER, 32'h0000_0000);
    @(posedge clk_sys);
    chk({31'h0, dplus_pullup_enable}, 32'h0000_0000);
    // Second endpoint completes but is not enabled
    wr(A_EP_IRQ_EN, 1);
    @(posedge clk_sys);
    ep_done <= 8'h03;
    ep_err <= 8'h01;
    @(posedge clk_sys);
    ep_done <= 8'h00;
    ep_err <= 8'h00;
    rd(A_EP_IRQ_STAT, 32'h0000_0001);
    rd(8'h60, 32'h0000_0080);
    // Second endpoint: stall on acknowledge-IN, NAK only with its enable
    wr(8'h64, 32'h0000_0006);
    wr(A_EP_IRQ_EN, 32'h0000_0003);
    ep_pulse(8'h02, 8'h00);
    rd(A_EP_IRQ_STAT, 32'h0000_0001);
    ep_pulse(8'h00, 8'h02);
    rd(A_EP_IRQ_STAT, 32'h0000_0003);
    wr(A_EP_IRQ_STAT, 32'h0000_0002);
    wr(8'h64, 32'h0000_0001);
    ep_pulse(8'h02, 8'h00);
    rd(A_EP_IRQ_STAT, 32'h0000_0003);
    wr(A_MEM_CFG, 0);
    wr(A_MEM_DATA, 32'h0000_1234);
    rd(A_MEM_DATA, 32'h0000_1234);
    rd(8'h80, 32'h0000_0101);
    // Engine reads word 0 through its own port
    wr(8'h80, 32'h0000_0000);
    sie_req <= 1;
    @(posedge clk_sys);
    chk({31'h0, sie_gnt}, 32'h0000_0001);
    sie_req <= 0;
    @(posedge clk_sys);
    chk({16'h0, sie_rdata}, 32'h0000_1234);
    rd(8'h80, 32'h0000_0100);
    // Automatic mode, inactive third endpoint: data and pointers refused
    wr(A_MEM_CFG, 32'h0000_0021);
    wr(A_MEM_DATA, 32'h0000_5555);
    rd(A_MEM_DATA, 32'h0000_0000);
    wr(8'h88, 32'h0000_0505);
    rd(8'h88, 32'h0000_0000);
    wr(A_EP0_LO, 32'h4433_2211);
    rd(A_EP0_LO, 32'h4433_2211);
    chk(ep0_data[31:0], 32'h4433_2211);
    // Pending endpoints 0 and 1 are sources 2 and 3, low line by default
    chk({29'h0, irq_line_low, irq_line_medium, irq_line_high}, 32'h0000_0004);
    wr(A_LVL_SEL, 32'h0000_0060);
    rd(A_CAUSE_HI, 32'h0000_0004);
    rd(A_CAUSE_MED, 32'h0000_0008);
    rd(A_CAUSE_LO, 32'h0000_0000);
    chk({29'h0, irq_line_low, irq_line_medium, irq_line_high}, 32'h0000_0003);
    arb_event <= 1;
    rd(A_CAUSE_LO, 32'h0000_2000);
    arb_event <= 0;
    final_report();
  end
endmodule
`default_nettype wire
